// file: i2c_host_model.sv
// Serial bus master model standing in for the configuring processor
`timescale 1ns/1ps

module i2c_host_model #(
	parameter [6:0] DEV_ADDR = 7'h20
)(
	input wire clk,
	input wire sdaOe,
	output reg scl,
	output wire sdaIn
);
	reg sdaDrive;
	reg ackBad;

	// ==========================================
	// Open-drain wire: the pull-up wins unless a party pulls low
	assign sdaIn = sdaDrive & ~sdaOe;

	initial
	begin
		scl = 1'b1;
		sdaDrive = 1'b1;
		ackBad = 1'b0;
	end

	// ==========================================
	// Bus phases, a quarter bit is 5 clocks so both clock phases last 10
	task quarter;
		repeat (5) @(negedge clk);
	endtask

	task start;
	begin
		sdaDrive = 1'b1;
		quarter;
		scl = 1'b1;
		quarter;
		sdaDrive = 1'b0;
		quarter;
		scl = 1'b0;
		quarter;
	end
	endtask

	task stop;
	begin
		sdaDrive = 1'b0;
		quarter;
		scl = 1'b1;
		quarter;
		sdaDrive = 1'b1;
		quarter;
	end
	endtask

	// Eight data bits then the acknowledge bit; driving 1 means releasing the wire
	task byteIo(input [7:0] tx, input ackIn, output [7:0] rx, output ackOut);
		reg [8:0] sh;
	begin
		sh = {tx, ackIn};
		repeat (9)
		begin
			sdaDrive = sh[8];
			quarter;
			scl = 1'b1;
			quarter;
			sh = {sh[7:0], sdaIn};
			quarter;
			scl = 1'b0;
			quarter;
		end
		rx = sh[8:1];
		ackOut = sh[0];
	end
	endtask

	task putByte(input [7:0] tx);
		reg [7:0] rx;
		reg a;
	begin
		byteIo(tx, 1'b1, rx, a);
		if (a !== 1'b0)
			ackBad = 1'b1;
	end
	endtask

	// ==========================================
	// Host operations
	task writeReg(input [7:0] ra, input [7:0] d);
	begin
		start;
		putByte({DEV_ADDR, 1'b0});
		putByte(ra);
		putByte(d);
		stop;
	end
	endtask

	task writeWord(input [7:0] ra, input [15:0] d);
	begin
		start;
		putByte({DEV_ADDR, 1'b0});
		putByte(ra);
		putByte(d[15:8]);
		putByte(d[7:0]);
		stop;
	end
	endtask

	task readReg(input [7:0] ra, output [7:0] d);
		reg a;
	begin
		start;
		putByte({DEV_ADDR, 1'b0});
		putByte(ra);
		start;
		putByte({DEV_ADDR, 1'b1});
		byteIo(8'hFF, 1'b1, d, a);
		stop;
	end
	endtask

	// The command byte's acknowledge overlaps the reset it causes, so it is not judged
	task generalCall(input [7:0] cmd);
		reg [7:0] rx;
		reg a;
	begin
		start;
		putByte(8'h00);
		byteIo(cmd, 1'b1, rx, a);
		stop;
	end
	endtask
endmodule

// file: i2c_target_link.v
// Serial bus target: bit framing, address match, acknowledge and byte strobes
`timescale 1ns/1ps

module i2c_target_link #(
	parameter [6:0] DEV_ADDR = 7'h20
)(
	input wire clk,
	input wire rst_n,
	input wire scl,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOe,
	output reg wrValid,
	output reg [7:0] wrData,
	output reg wrFirst,
	output reg wrGeneral,
	output reg rdReq,
	input wire [7:0] rdData
);
`include "imager_ctrl_map.vh"

	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_ADDR = 3'd1;
	localparam [2:0] S_ADDR_ACK = 3'd2;
	localparam [2:0] S_WRITE = 3'd3;
	localparam [2:0] S_WRITE_ACK = 3'd4;
	localparam [2:0] S_READ = 3'd5;
	localparam [2:0] S_READ_ACK = 3'd6;

	reg sclMeta, sclSync, sclLast;
	reg sdaMeta, sdaSync, sdaLast;
	reg [2:0] state;
	reg [3:0] bitCnt;
	reg [7:0] shift;
	reg [7:0] txByte;
	reg isRead, isGeneral, firstPending;

	wire sclRise = sclSync & ~sclLast;
	wire sclFall = ~sclSync & sclLast;
	wire startCond = sclSync & sclLast & sdaLast & ~sdaSync;
	wire stopCond = sclSync & sclLast & ~sdaLast & sdaSync;
	wire addrHit = (shift[7:1] == DEV_ADDR) || (shift[7:1] == `GENERAL_CALL_ADDR && !shift[0]);

	// ==========================================
	// Framing state machine
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			sclMeta <= 1'b1; sclSync <= 1'b1; sclLast <= 1'b1;
			sdaMeta <= 1'b1; sdaSync <= 1'b1; sdaLast <= 1'b1;
			state <= S_IDLE; bitCnt <= 4'h0; shift <= 8'h00; txByte <= 8'h00;
			isRead <= 1'b0; isGeneral <= 1'b0; firstPending <= 1'b0;
			sdaOut <= 1'b0; sdaOe <= 1'b0; wrValid <= 1'b0; wrData <= 8'h00;
			wrFirst <= 1'b0; wrGeneral <= 1'b0; rdReq <= 1'b0;
		end
		else
		begin
			sclMeta <= scl; sclSync <= sclMeta; sclLast <= sclSync;
			sdaMeta <= sdaIn; sdaSync <= sdaMeta; sdaLast <= sdaSync;
			wrValid <= 1'b0;
			rdReq <= 1'b0;
			if (startCond)
			begin
				state <= S_ADDR;
				bitCnt <= 4'h0;
				sdaOe <= 1'b0;
			end
			else if (stopCond)
			begin
				state <= S_IDLE;
				sdaOe <= 1'b0;
			end
			else
			begin
				case (state)
				S_ADDR, S_WRITE:
					if (sclRise)
					begin
						shift <= {shift[6:0], sdaSync};
						bitCnt <= bitCnt + 4'h1;
					end
					else if (sclFall && bitCnt == 4'h8)
					begin
						bitCnt <= 4'h0;
						if (state == S_ADDR)
						begin
							if (addrHit)
							begin
								sdaOe <= 1'b1;
								isRead <= shift[0];
								isGeneral <= (shift[7:1] == `GENERAL_CALL_ADDR);
								firstPending <= 1'b1;
								rdReq <= shift[0];
								state <= S_ADDR_ACK;
							end
							else
								state <= S_IDLE;
						end
						else
						begin
							sdaOe <= 1'b1;
							wrValid <= 1'b1;
							wrData <= shift;
							wrFirst <= firstPending;
							wrGeneral <= isGeneral;
							firstPending <= 1'b0;
							state <= S_WRITE_ACK;
						end
					end
				S_ADDR_ACK:
					if (sclFall)
					begin
						if (isRead)
						begin
							// First bit goes out on the same fall that ends the acknowledge
							txByte <= {rdData[6:0], 1'b0};
							sdaOe <= ~rdData[7];
							bitCnt <= 4'h1;
							state <= S_READ;
						end
						else
						begin
							sdaOe <= 1'b0;
							state <= S_WRITE;
						end
					end
				S_WRITE_ACK:
					if (sclFall)
					begin
						sdaOe <= 1'b0;
						state <= S_WRITE;
					end
				S_READ:
					if (sclFall)
					begin
						if (bitCnt == 4'h8)
						begin
							sdaOe <= 1'b0;
							state <= S_READ_ACK;
						end
						else
						begin
							sdaOe <= ~txByte[7];
							txByte <= {txByte[6:0], 1'b0};
							bitCnt <= bitCnt + 4'h1;
						end
					end
				S_READ_ACK:
					if (sclRise)
					begin
						// A not-acknowledge ends the read; the master then stops
						if (sdaSync)
							state <= S_IDLE;
						else
						begin
							rdReq <= 1'b1;
							state <= S_ADDR_ACK;
						end
					end
				default:
					state <= S_IDLE;
				endcase
			end
		end
	end

endmodule

// file: imager_control_eeprom_access.v
// Imager command logic: soft reset, acquisition setup and trigger, indirect nonvolatile access
`timescale 1ns/1ps
`include "imager_ctrl_map.vh"

module imager_control_eeprom_access #(
	parameter [6:0] DEV_ADDR = 7'h20,
	parameter [7:0] SILICON_VERSION = 8'h11,
	parameter PROGRAM_CYCLES = `NVM_PROGRAM_CYCLES,
	parameter READOUT_CYCLES = 64
)(
	input wire clk,
	input wire rst_n,
	input wire scl,
	input wire sdaIn,
	output wire sdaOut,
	output wire sdaOe,
	output reg ready,
	output reg acqBusy,
	output reg integrating,
	output reg [1:0] phaseSample,
	output reg [1:0] modulationSelect,
	output reg nvmBusyOut
);

	localparam NB = 7;
	localparam [1:0] A_IDLE = 2'd0;
	localparam [1:0] A_INTEGRATE = 2'd1;
	localparam [1:0] A_READOUT = 2'd2;
	// Counts are worked out at full width, then cut to the counter widths on purpose
	localparam integer HOLD_FULL = `RESET_HOLD_CYCLES - 1;
	localparam integer UNIT_FULL = `INT_UNIT_CYCLES - 1;
	localparam integer RO_FULL = READOUT_CYCLES - 1;
	localparam [4:0] HOLD_LAST = HOLD_FULL[4:0];
	localparam [2:0] UNIT_LAST = UNIT_FULL[2:0];
	localparam [7:0] RO_LAST = RO_FULL[7:0];

	// ==========================================
	// Internal reset: pin or general call
	reg swHold;
	reg [4:0] swCnt;
	wire sysRst_n = rst_n & ~swHold;

	wire wrValid, wrFirst, wrGeneral, rdReq;
	wire [7:0] wrData;
	reg [7:0] rdByte;
	wire [7:0] nvmRdData;
	wire nvmBusy, nvmDone;

	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			swHold <= 1'b0;
			swCnt <= 5'h00;
		end
		else if (swHold)
		begin
			// Held long enough for the whole device to settle, like a pin pulse
			if (swCnt == HOLD_LAST)
				swHold <= 1'b0;
			swCnt <= swCnt + 5'h01;
		end
		else if (wrValid && wrGeneral && wrData == `CMD_SOFT_RESET)
		begin
			swHold <= 1'b1;
			swCnt <= 5'h00;
		end
	end

	// ==========================================
	// Register state
	reg [7:0] regAddr;
	reg [7:0] nvmPointer;
	reg [7:0] modCtrl;
	reg [7:0] intHi;
	reg [7:0] intLo;
	reg [7:0] shutterCtrl;
	reg [1:0] loadStep;
	reg [1:0] acqState;
	reg [2:0] unitCnt;
	reg [15:0] intCnt;
	reg [15:0] intLatched;
	reg [7:0] roCnt;
	reg [1:0] sampleLast;

	function [NB-1:0] nvmIndex;
		input [7:0] addr;
		begin
			nvmIndex = addr[NB-1:0];
		end
	endfunction

	function [7:0] loadAddr;
		input [1:0] step;
		begin
			case (step)
			2'd0: loadAddr = `REG_MODULATION_CONTROL;
			2'd1: loadAddr = `REG_INTEGRATION_HI;
			default: loadAddr = `REG_INTEGRATION_LO;
			endcase
		end
	endfunction

	wire dataWr = wrValid && !wrFirst && !wrGeneral;
	wire windowWr = dataWr && regAddr == `REG_NVM_WINDOW && !nvmBusy;
	wire windowRd = rdReq && regAddr == `REG_NVM_WINDOW;
	wire shutterRelease = dataWr && regAddr == `REG_SHUTTER_CONTROL && wrData[`FLD_SHUTTER_RELEASE] && acqState == A_IDLE;
	wire [NB-1:0] nvmRdAddr = ready ? nvmIndex(nvmPointer) : nvmIndex(loadAddr(loadStep));

	// ==========================================
	// Read multiplexer
	always @*
	begin
		case (regAddr)
		`REG_SILICON_VERSION: rdByte = SILICON_VERSION;
		`REG_NVM_POINTER: rdByte = nvmPointer;
		`REG_NVM_WINDOW: rdByte = nvmRdData;
		`REG_MODULATION_CONTROL: rdByte = modCtrl;
		`REG_INTEGRATION_HI: rdByte = intHi;
		`REG_INTEGRATION_LO: rdByte = intLo;
		`REG_SHUTTER_CONTROL: rdByte = shutterCtrl;
		default: rdByte = 8'h00;
		endcase
	end

	reg [7:0] rdLatched;

	// ==========================================
	// Register writes, reset load and pointer
	always @(posedge clk)
	begin
		if (!sysRst_n)
		begin
			regAddr <= 8'h00;
			nvmPointer <= `RST_NVM_POINTER;
			modCtrl <= 8'h00;
			intHi <= 8'h00;
			intLo <= 8'h00;
			loadStep <= 2'd0;
			ready <= 1'b0;
			rdLatched <= 8'h00;
			nvmBusyOut <= 1'b0;
		end
		else
		begin
			nvmBusyOut <= nvmBusy;
			if (!ready)
			begin
				// Working copies come from the array only in this window after reset
				case (loadStep)
				2'd0: modCtrl <= nvmRdData;
				2'd1: intHi <= nvmRdData;
				default: intLo <= nvmRdData;
				endcase
				loadStep <= loadStep + 2'd1;
				if (loadStep == 2'd2)
					ready <= 1'b1;
			end
			if (rdReq)
				rdLatched <= rdByte;
			if (wrValid && wrFirst && !wrGeneral)
				regAddr <= wrData;
			else if (dataWr || rdReq)
				regAddr <= regAddr + 8'h01;
			if (dataWr && regAddr == `REG_NVM_POINTER)
				nvmPointer <= wrData;
			else if (nvmDone || windowRd)
				nvmPointer <= nvmPointer + 8'h01;
			if (ready && dataWr && acqState == A_IDLE)
			begin
				case (regAddr)
				`REG_MODULATION_CONTROL: modCtrl <= wrData;
				`REG_INTEGRATION_HI: intHi <= wrData;
				`REG_INTEGRATION_LO: intLo <= wrData;
				default: ;
				endcase
			end
		end
	end

	// ==========================================
	// Acquisition sequencer
	always @(posedge clk)
	begin
		if (!sysRst_n)
		begin
			shutterCtrl <= `RST_SHUTTER_CONTROL;
			acqState <= A_IDLE;
			acqBusy <= 1'b0;
			integrating <= 1'b0;
			phaseSample <= 2'd0;
			modulationSelect <= 2'd0;
			unitCnt <= 3'd0;
			intCnt <= 16'h0000;
			intLatched <= 16'h0000;
			roCnt <= 8'h00;
			sampleLast <= 2'd0;
		end
		else
		begin
			case (acqState)
			A_IDLE:
				if (ready && shutterRelease)
				begin
					// Settings are sampled here; writes to them are dropped until the acquisition ends
					shutterCtrl <= wrData;
					intLatched <= {intHi, intLo};
					sampleLast <= modCtrl[`FLD_COUNT_HI:`FLD_COUNT_LO];
					modulationSelect <= modCtrl[`FLD_MODSEL_HI:`FLD_MODSEL_LO];
					phaseSample <= 2'd0;
					unitCnt <= 3'd0;
					intCnt <= 16'h0000;
					acqBusy <= 1'b1;
					integrating <= 1'b1;
					acqState <= A_INTEGRATE;
				end
				else if (dataWr && regAddr == `REG_SHUTTER_CONTROL)
					shutterCtrl <= wrData;
			A_INTEGRATE:
				if (unitCnt == UNIT_LAST)
				begin
					unitCnt <= 3'd0;
					// Length value N integrates for N+1 time units
					if (intCnt == intLatched)
					begin
						integrating <= 1'b0;
						roCnt <= 8'h00;
						acqState <= A_READOUT;
					end
					else
						intCnt <= intCnt + 16'h0001;
				end
				else
					unitCnt <= unitCnt + 3'd1;
			A_READOUT:
				if (roCnt == RO_LAST)
				begin
					if (phaseSample == sampleLast)
					begin
						acqBusy <= 1'b0;
						shutterCtrl[`FLD_SHUTTER_RELEASE] <= 1'b0;
						acqState <= A_IDLE;
					end
					else
					begin
						phaseSample <= phaseSample + 2'd1;
						unitCnt <= 3'd0;
						intCnt <= 16'h0000;
						integrating <= 1'b1;
						acqState <= A_INTEGRATE;
					end
				end
				else
					roCnt <= roCnt + 8'h01;
			default:
				acqState <= A_IDLE;
			endcase
		end
	end

	// ==========================================
	// Submodules
	i2c_target_link #(
		.DEV_ADDR(DEV_ADDR)
	) link (
		.clk(clk),
		.rst_n(sysRst_n),
		.scl(scl),
		.sdaIn(sdaIn),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.wrValid(wrValid),
		.wrData(wrData),
		.wrFirst(wrFirst),
		.wrGeneral(wrGeneral),
		.rdReq(rdReq),
		.rdData(rdLatched)
	);

	nvm_store #(
		.DEPTH_BITS(NB),
		.PROGRAM_CYCLES(PROGRAM_CYCLES)
	) nvm (
		.clk(clk),
		.rst_n(sysRst_n),
		.rdAddr(nvmRdAddr),
		.rdData(nvmRdData),
		.wrStart(windowWr),
		.wrAddr(nvmIndex(nvmPointer)),
		.wrData(wrData),
		.busy(nvmBusy),
		.done(nvmDone)
	);

endmodule

// file: imager_control_eeprom_access_tb.sv
// Self-checking bench for the imager command block
`timescale 1ns/1ps
`include "imager_ctrl_map.vh"

module imager_control_eeprom_access_tb;
	localparam PROG = 400;
	localparam [7:0] SI_VER = 8'h11;
	// Identity bytes held by the array model, arbitrary values
	localparam [31:0] ID_BYTES = 32'h1234_5678;
	reg clk;
	reg rstN;
	wire scl, sdaIn, sdaOut, sdaOe, ready, acqBusy, integrating, nvmBusyOut;
	wire [1:0] phaseSample;
	wire [1:0] modulationSelect;
	integer mismatches, samplesChecked, intCycles, intRises, i;
	reg [7:0] rd;
	reg [1:0] lastPhase;
	reg prevInt;

	imager_control_eeprom_access #(.SILICON_VERSION(SI_VER), .PROGRAM_CYCLES(PROG), .READOUT_CYCLES(64)) dut_u (
		.clk(clk), .rst_n(rstN), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .ready(ready),
		.acqBusy(acqBusy), .integrating(integrating), .phaseSample(phaseSample),
		.modulationSelect(modulationSelect), .nvmBusyOut(nvmBusyOut));
	i2c_host_model #(.DEV_ADDR(7'h20)) hostU (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));

	// ==========================================
	// Acquisition monitor
	// Sampled on the falling edge, where the outputs have settled
	always @(negedge clk)
	begin
		if (integrating === 1'b1)
		begin
			intCycles = intCycles + 1;
			lastPhase = phaseSample;
			if (!prevInt)
				intRises = intRises + 1;
		end
		prevInt = (integrating === 1'b1);
	end

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ==========================================
	// Checking tasks
	task check(input [31:0] got, input [31:0] exp);
	begin
		samplesChecked = samplesChecked + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task readCheck(input [7:0] ra, input [7:0] exp);
	begin
		hostU.readReg(ra, rd);
		check(rd, exp);
	end
	endtask

	task endTest(input string name);
		$display("Test %0s finished", name);
	endtask

	task waitReady;
	begin
		for (i = 0; i < 100 && ready !== 1'b1; i = i + 1)
			@(negedge clk);
		check(ready, 1);
	end
	endtask

	task acquire(input [7:0] mode, input [15:0] len, input integer count);
	begin
		hostU.writeReg(`REG_MODULATION_CONTROL, mode);
		hostU.writeWord(`REG_INTEGRATION_HI, len);
		intCycles = 0;
		intRises = 0;
		hostU.writeReg(`REG_SHUTTER_CONTROL, 8'h01);
		for (i = 0; i < 20000 && acqBusy !== 1'b0; i = i + 1)
			@(negedge clk);
		check(acqBusy, 0);
		check(intRises, count);
		check(intCycles, count * (len + 1) * 5);
		check(lastPhase, count - 1);
		check(modulationSelect, mode[7:6]);
		readCheck(`REG_SHUTTER_CONTROL, 8'h00);
	end
	endtask

	task results;
	begin
		$display("Checks made %0d, mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		mismatches = 0;
		samplesChecked = 0;
		intCycles = 0;
		intRises = 0;
		prevInt = 1'b0;
		rstN = 1'b0;
		repeat (20) @(negedge clk);
		rstN = 1'b1;
		waitReady;
		readCheck(`REG_SILICON_VERSION, SI_VER);
		readCheck(8'h55, 8'h00);
		endTest("direct");
		acquire(8'h14, 16'h031F, 2);
		acquire(8'h54, 16'h0003, 2);
		acquire(8'h34, 16'h0013, 4);
		readCheck(`REG_INTEGRATION_LO, 8'h13);
		endTest("acquisition");
		hostU.writeReg(`REG_NVM_POINTER, `NVM_PART_VERSION);
		readCheck(`REG_NVM_WINDOW, 8'h3C);
		hostU.writeReg(`REG_NVM_POINTER, `NVM_WAFER_ID_HI);
		for (i = 0; i < 4; i = i + 1)
			readCheck(`REG_NVM_WINDOW, ID_BYTES[8 * (3 - i) +: 8]);
		readCheck(`REG_NVM_POINTER, 8'hFA);
		endTest("identity");
		// Programming is held off only while an earlier programming cycle runs
		hostU.writeReg(`REG_NVM_POINTER, `REG_MODULATION_CONTROL);
		hostU.writeReg(`REG_NVM_WINDOW, 8'h24);
		check(nvmBusyOut, 1);
		for (i = 0; i < 1000 && nvmBusyOut !== 1'b0; i = i + 1)
			@(negedge clk);
		check(nvmBusyOut, 0);
		readCheck(`REG_NVM_POINTER, 8'h93);
		readCheck(`REG_MODULATION_CONTROL, 8'h34);
		hostU.writeReg(`REG_NVM_POINTER, `REG_MODULATION_CONTROL);
		readCheck(`REG_NVM_WINDOW, 8'h24);
		readCheck(`REG_MODULATION_CONTROL, 8'h34);
		endTest("nonvolatile");
		hostU.generalCall(`CMD_SOFT_RESET);
		// Internal reset hold plus the load, both fixed in cycles
		repeat (40) @(negedge clk);
		waitReady;
		readCheck(`REG_MODULATION_CONTROL, 8'h24);
		readCheck(`REG_NVM_POINTER, `RST_NVM_POINTER);
		readCheck(`REG_INTEGRATION_HI, 8'h00);
		check(hostU.ackBad, 0);
		check(sdaOut, 0);
		endTest("soft reset");
		results;
	end

	initial
	begin
		#400000;
		mismatches = mismatches + 1;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		results;
	end
endmodule

bind imager_control_eeprom_access imager_ctrl_sva #(.PROGRAM_CYCLES(PROGRAM_CYCLES), .READOUT_CYCLES(READOUT_CYCLES)) checkU (
	.clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .ready(ready),
	.acqBusy(acqBusy), .integrating(integrating), .phaseSample(phaseSample),
	.modulationSelect(modulationSelect), .nvmBusyOut(nvmBusyOut));

// file: imager_ctrl_map.vh
// Register offsets, field positions, reset values and timing counts of the imager control block
`ifndef IMAGER_CTRL_MAP_VH
`define IMAGER_CTRL_MAP_VH

// ==========================================
// Register offsets
`define REG_SILICON_VERSION 8'h01
`define REG_NVM_POINTER 8'h11
`define REG_NVM_WINDOW 8'h12
`define REG_MODULATION_CONTROL 8'h92
`define REG_INTEGRATION_HI 8'hA2
`define REG_INTEGRATION_LO 8'hA3
`define REG_SHUTTER_CONTROL 8'hA4

// ==========================================
// Nonvolatile byte addresses without working copies
`define NVM_WAFER_ID_HI 8'hF6
`define NVM_WAFER_ID_LO 8'hF7
`define NVM_CHIP_ID_HI 8'hF8
`define NVM_CHIP_ID_LO 8'hF9
`define NVM_PART_VERSION 8'hFB

// ==========================================
// Serial bus commands
`define GENERAL_CALL_ADDR 7'h00
`define CMD_SOFT_RESET 8'h06

// ==========================================
// Field positions
`define FLD_MODSEL_HI 7
`define FLD_MODSEL_LO 6
`define FLD_COUNT_HI 5
`define FLD_COUNT_LO 4
`define FLD_SHUTTER_RELEASE 0

// ==========================================
// Reset values
`define RST_NVM_POINTER 8'h00
`define RST_SHUTTER_CONTROL 8'h00

// ==========================================
// Timing
`define CLK_PERIOD_PS 4000
`define RESET_HOLD_NS 100
`define RESET_HOLD_CYCLES ((`RESET_HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define NVM_PROGRAM_MS 20
`define NVM_PROGRAM_CYCLES (`NVM_PROGRAM_MS * (1000000000 / `CLK_PERIOD_PS))
`define INT_UNIT_PS 20833
`define INT_UNIT_CYCLES (`INT_UNIT_PS / `CLK_PERIOD_PS)

`endif

// file: imager_ctrl_sva.sv
// Concurrent checks on the ports of the imager command block
`timescale 1ns/1ps

module imager_ctrl_sva #(
	parameter PROGRAM_CYCLES = 50,
	parameter READOUT_CYCLES = 64
)(
	input wire clk,
	input wire rst_n,
	input wire scl,
	input wire sdaIn,
	input wire sdaOut,
	input wire sdaOe,
	input wire ready,
	input wire acqBusy,
	input wire integrating,
	input wire [1:0] phaseSample,
	input wire [1:0] modulationSelect,
	input wire nvmBusyOut
);
	reg [31:0] busyCnt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ==========================================
	// Length of the running programming cycle
	always @(posedge clk)
	begin
		if (!rst_n || !nvmBusyOut)
			busyCnt <= 32'h0000_0000;
		else
			busyCnt <= busyCnt + 32'h0000_0001;
	end

	// ==========================================
	// Assertions
	AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n |=> !ready && !acqBusy && !sdaOe && !nvmBusyOut)
		else $error("outputs not cleared under reset");
	AST_READY_LOAD: assert property ($rose(rst_n) |-> !ready ##1 !ready ##[1:4] ready)
		else $error("ready not raised after reset load");
	AST_ACQ_START: assert property ($rose(acqBusy) |-> integrating && phaseSample == 2'h0)
		else $error("acquisition did not start with first sample");
	AST_INT_IN_ACQ: assert property (integrating |-> acqBusy)
		else $error("integration outside an acquisition");
	AST_PHASE_STEP: assert property ($rose(integrating) && $past(acqBusy) |-> phaseSample == $past(phaseSample) + 2'h1)
		else $error("sample index did not step by one");
	AST_MODSEL_HOLD: assert property (acqBusy && $past(acqBusy) |-> $stable(modulationSelect))
		else $error("modulation select changed during acquisition");
	AST_READOUT_GAP: assert property (acqBusy && $fell(integrating) |-> !integrating [*8])
		else $error("readout gap too short");
	AST_NVM_LENGTH: assert property ($fell(nvmBusyOut) |-> busyCnt >= PROGRAM_CYCLES - 1 && busyCnt <= PROGRAM_CYCLES + 1)
		else $error("programming cycle length wrong");

	COV_ACQ: cover property ($rose(acqBusy));
	COV_FOUR: cover property (acqBusy && phaseSample == 2'h3);
	COV_NVM: cover property ($fell(nvmBusyOut));
endmodule

// file: nvm_store.v
// Nonvolatile byte array with timed erase-and-program cycle
`timescale 1ns/1ps

module nvm_store #(
	parameter DEPTH_BITS = 7,
	parameter PROGRAM_CYCLES = 5000000,
	parameter [7:0] PART_VERSION = 8'h3C,
	parameter [15:0] WAFER_ID = 16'h1234,
	parameter [15:0] CHIP_ID = 16'h5678
)(
	input wire clk,
	input wire rst_n,
	input wire [DEPTH_BITS-1:0] rdAddr,
	output wire [7:0] rdData,
	input wire wrStart,
	input wire [DEPTH_BITS-1:0] wrAddr,
	input wire [7:0] wrData,
	output reg busy,
	output reg done
);
`include "imager_ctrl_map.vh"

	localparam CW = 23;
	localparam integer LAST_FULL = PROGRAM_CYCLES - 1;
	localparam [CW-1:0] LAST = LAST_FULL[CW-1:0];
	localparam [7:0] A_PART = `NVM_PART_VERSION;
	localparam [7:0] A_WHI = `NVM_WAFER_ID_HI;
	localparam [7:0] A_WLO = `NVM_WAFER_ID_LO;
	localparam [7:0] A_CHI = `NVM_CHIP_ID_HI;
	localparam [7:0] A_CLO = `NVM_CHIP_ID_LO;

	reg [7:0] cells [0:(1<<DEPTH_BITS)-1];
	reg [CW-1:0] cnt;
	reg [DEPTH_BITS-1:0] pendAddr;
	reg [7:0] pendData;
	integer i;

	// Factory contents stand in for what a real array keeps across power cycles
	initial
	begin
		for (i = 0; i < (1<<DEPTH_BITS); i = i + 1)
			cells[i] = 8'h00;
		cells[A_PART[DEPTH_BITS-1:0]] = PART_VERSION;
		cells[A_WHI[DEPTH_BITS-1:0]] = WAFER_ID[15:8];
		cells[A_WLO[DEPTH_BITS-1:0]] = WAFER_ID[7:0];
		cells[A_CHI[DEPTH_BITS-1:0]] = CHIP_ID[15:8];
		cells[A_CLO[DEPTH_BITS-1:0]] = CHIP_ID[7:0];
	end

	assign rdData = cells[rdAddr];

	// ==========================================
	// Program timer; the byte only changes when the cycle completes
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= {CW{1'b0}};
			pendAddr <= {DEPTH_BITS{1'b0}};
			pendData <= 8'h00;
		end
		else
		begin
			done <= 1'b0;
			if (!busy && wrStart)
			begin
				busy <= 1'b1;
				cnt <= {CW{1'b0}};
				pendAddr <= wrAddr;
				pendData <= wrData;
			end
			else if (busy)
			begin
				if (cnt == LAST)
				begin
					busy <= 1'b0;
					done <= 1'b1;
					cells[pendAddr] <= pendData;
				end
				else
					cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule
